// ==== rtl/chgadc_regs.svh ====
`ifndef CHGADC_REGS_SVH
`define CHGADC_REGS_SVH
// =====================================================
// command codes
`define CHGADC_CMD_CUR_CMP 8'h25
`define CHGADC_CMD_SYS_BAT 8'h26
`define CHGADC_CMD_MAKER 8'hfe
`define CHGADC_CMD_PART 8'hff
// =====================================================
// field positions
`define CHGADC_HI_MSB 15
`define CHGADC_HI_LSB 8
`define CHGADC_LO_MSB 7
`define CHGADC_LO_LSB 0
// =====================================================
// reset values
`define CHGADC_RESULT_RST 8'h00
`define CHGADC_WORD_RST 16'h0000
// identity codes, arbitrary values
`define CHGADC_MAKER_CODE 16'h00a5
`define CHGADC_PART_CODE 8'h3c
`endif

// ==== rtl/chgadc_pkg.sv ====
package chgadc_pkg;
  // which result field a conversion targets
  typedef enum logic [1:0]
  {
    CHGADC_CH_CUR = 2'b00,
    CHGADC_CH_CMP = 2'b01,
    CHGADC_CH_SYS = 2'b10,
    CHGADC_CH_BAT = 2'b11
  } chgadc_chan_t;
  // read path state
  typedef enum logic [0:0]
  {
    CHGADC_IDLE = 1'b0,
    CHGADC_ANSWER = 1'b1
  } chgadc_rd_state_t;
endpackage

// ==== rtl/chgadc_cnv_if.sv ====
`timescale 1ns/100ps
// conversion update carrier between top and result holders
interface chgadc_cnv_if;
  logic valid; // one-cycle update strobe
  chgadc_pkg::chgadc_chan_t chan; // target field
  logic [7:0] code; // converted code
  modport src (output valid, output chan, output code);
  modport dst (input valid, input chan, input code);
endinterface

// ==== rtl/chgadc_field.sv ====
`timescale 1ns/100ps
`include "chgadc_regs.svh"
// =====================================================
// one 8-bit result field holding last conversion
module chgadc_field #(
  parameter chgadc_pkg::chgadc_chan_t CHAN = chgadc_pkg::CHGADC_CH_CUR
) (
  input wire logic mclk,
  input wire logic resetn,
  chgadc_cnv_if.dst cnv,
  output logic [7:0] value
);
  logic [7:0] value_ff; // held code
  logic [7:0] nxt_value;
  // update only on a matching conversion
  always_comb
  begin
    nxt_value = value_ff;
    if (cnv.valid && cnv.chan == CHAN)
    begin
      nxt_value = cnv.code;
    end
  end
  // register
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      value_ff <= `CHGADC_RESULT_RST;
    else
      value_ff <= nxt_value;
  end
  assign value = value_ff;
endmodule

// ==== rtl/chgadc_regbank.sv ====
`timescale 1ns/100ps
`include "chgadc_regs.svh"
// Operation
// - input current high byte, 50 mA steps
// - comparator voltage low byte, 12 mV steps
// - system voltage high byte, 64 mV steps
// - battery voltage low byte, 64 mV steps
// - result words at 25h, 26h, read-only
// - fixed maker code at FEh, unwritable
// - part code at FFh, upper byte zero
module chgadc_regbank (
  input wire logic mclk,
  input wire logic resetn,
  // conversion results from the adc sequencer
  input wire logic cnv_valid,
  input wire logic [1:0] cnv_chan,
  input wire logic [7:0] cnv_code,
  // command port from the smbus engine
  input wire logic cmd_rd,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_miss
);
  // =====================================================
  // conversion update carrier
  chgadc_cnv_if cnv (); // shared update bus to all four holders
  logic [7:0] cur_code; // input_current_result, high byte at 25h
  logic [7:0] cmp_code; // comparator_input_voltage, low byte at 25h
  logic [7:0] sys_code; // system_voltage_result, high byte at 26h
  logic [7:0] bat_code; // battery voltage, low byte at 26h
  // sequencer strobe goes straight onto the carrier, same clock
  assign cnv.valid = cnv_valid;
  // channel number maps one to one onto the holder selector
  assign cnv.chan = chgadc_pkg::chgadc_chan_t'(cnv_chan);
  // code only matters while the strobe is high
  assign cnv.code = cnv_code;
  // =====================================================
  // result holders
  // input current, 50 mA a step, top code 12.75 A
  chgadc_field #(
    .CHAN(chgadc_pkg::CHGADC_CH_CUR)
  ) u_cur (
    .mclk(mclk),
    .resetn(resetn),
    .cnv(cnv),
    .value(cur_code)
  );
  // comparator input, 12 mV a step, top code 3.06 V
  chgadc_field #(
    .CHAN(chgadc_pkg::CHGADC_CH_CMP)
  ) u_cmp (
    .mclk(mclk),
    .resetn(resetn),
    .cnv(cnv),
    .value(cmp_code)
  );
  // system voltage, 64 mV a step above a 2.88 V base
  chgadc_field #(
    .CHAN(chgadc_pkg::CHGADC_CH_SYS)
  ) u_sys (
    .mclk(mclk),
    .resetn(resetn),
    .cnv(cnv),
    .value(sys_code)
  );
  // battery voltage, same 64 mV step, up to 19.2 V
  chgadc_field #(
    .CHAN(chgadc_pkg::CHGADC_CH_BAT)
  ) u_bat (
    .mclk(mclk),
    .resetn(resetn),
    .cnv(cnv),
    .value(bat_code)
  );
  // =====================================================
  // command decode
  logic rd_take; // read accepted at this edge
  logic hit_cur_cmp; // current and comparator word
  logic hit_sys_bat; // system and battery voltage word
  logic hit_maker; // maker identification word
  logic hit_part; // part identification word
  logic hit_none; // code outside the map
  logic [15:0] unused_wdata; // write data is dropped
  // writes carry nothing into the bank, so their data goes nowhere
  assign unused_wdata = cmd_wdata;
  // a read with a write beside it counts as a write and is dropped
  assign rd_take = cmd_rd && !cmd_wr;
  // one hit flag per mapped word, only the miss flag for a foreign code
  always_comb
  begin
    hit_cur_cmp = 1'b0;
    hit_sys_bat = 1'b0;
    hit_maker = 1'b0;
    hit_part = 1'b0;
    hit_none = 1'b0;
    unique case (cmd_code)
      `CHGADC_CMD_CUR_CMP:
      begin
        hit_cur_cmp = 1'b1;
      end
      `CHGADC_CMD_SYS_BAT:
      begin
        hit_sys_bat = 1'b1;
      end
      `CHGADC_CMD_MAKER:
      begin
        hit_maker = 1'b1;
      end
      `CHGADC_CMD_PART:
      begin
        hit_part = 1'b1;
      end
      default:
      begin
        hit_none = 1'b1; // unmapped code
      end
    endcase
  end
  // =====================================================
  // answer word selection
  logic [15:0] sel_word; // word the decoded code points at
  // pack two byte results, or a fixed code, into one word
  always_comb
  begin
    sel_word = `CHGADC_WORD_RST; // foreign codes read as zero
    if (hit_cur_cmp)
    begin
      sel_word[`CHGADC_HI_MSB:`CHGADC_HI_LSB] = cur_code;
      sel_word[`CHGADC_LO_MSB:`CHGADC_LO_LSB] = cmp_code;
    end
    else if (hit_sys_bat)
    begin
      sel_word[`CHGADC_HI_MSB:`CHGADC_HI_LSB] = sys_code;
      sel_word[`CHGADC_LO_MSB:`CHGADC_LO_LSB] = bat_code;
    end
    else if (hit_maker)
    begin
      sel_word = `CHGADC_MAKER_CODE;
    end
    else if (hit_part)
    begin
      // upper byte keeps the zero default
      sel_word[`CHGADC_LO_MSB:`CHGADC_LO_LSB] = `CHGADC_PART_CODE;
    end
  end
  // =====================================================
  // answer sequencing
  chgadc_pkg::chgadc_rd_state_t state_ff; // answer pending
  chgadc_pkg::chgadc_rd_state_t nxt_state;
  logic rd_valid_ff; // answer strobe, one cycle per taken read
  logic nxt_rd_valid;
  // every taken read is answered exactly one edge later
  always_comb
  begin
    nxt_state = chgadc_pkg::CHGADC_IDLE;
    unique case (state_ff)
      chgadc_pkg::CHGADC_IDLE:
      begin
        if (rd_take)
        begin
          nxt_state = chgadc_pkg::CHGADC_ANSWER;
        end
      end
      chgadc_pkg::CHGADC_ANSWER:
      begin
        // back to back reads keep the strobe up
        if (rd_take)
        begin
          nxt_state = chgadc_pkg::CHGADC_ANSWER;
        end
      end
    endcase
    nxt_rd_valid = (nxt_state == chgadc_pkg::CHGADC_ANSWER);
  end
  // register state and strobe
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_ff <= chgadc_pkg::CHGADC_IDLE;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rd_valid_ff <= nxt_rd_valid;
    end
  end
  // =====================================================
  // answer word and miss flag
  logic [15:0] rd_data_ff; // last answer, held until the next read
  logic [15:0] nxt_rd_data;
  logic rd_miss_ff; // foreign code flag, rides with the strobe
  logic nxt_rd_miss;
  // only a taken read loads a new word; writes leave it alone
  always_comb
  begin
    nxt_rd_data = rd_data_ff;
    nxt_rd_miss = 1'b0;
    if (rd_take)
    begin
      nxt_rd_data = sel_word;
      nxt_rd_miss = hit_none; // unmapped code
    end
  end
  // register answer word and flag
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rd_data_ff <= `CHGADC_WORD_RST;
      rd_miss_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
      rd_miss_ff <= nxt_rd_miss;
    end
  end
  // =====================================================
  // outputs, each straight from a flip-flop
  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_miss = rd_miss_ff;
endmodule

// ==== dv/chgadc_host.sv ====
`timescale 1ns/100ps
// ===
module chgadc_host ( // host side, one command per call
  input wire logic mclk,
  output logic cmd_rd = 1'h0,
  output logic cmd_wr = 1'h0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [15:0] cmd_wdata = 16'h0000
);
  task automatic req(input logic r, input logic [7:0] c, input logic [15:0] w); // ends at taking edge
    {cmd_rd, cmd_wr, cmd_code, cmd_wdata} <= {r, !r, c, w};
    @(posedge mclk);
    {cmd_rd, cmd_wr, cmd_code, cmd_wdata} <= {2'h0, ~c, ~w}; // released bus scrambled
  endtask
  task automatic req_both(input logic [7:0] c); // read and write raised together
    {cmd_rd, cmd_wr, cmd_code} <= {2'h3, c};
    @(posedge mclk);
    {cmd_rd, cmd_wr, cmd_code} <= {2'h0, ~c}; // released bus scrambled
  endtask
endmodule

// ==== dv/chgadc_monitor.sv ====
`timescale 1ns/100ps
// ===
module chgadc_monitor ( // port checks of the result bank
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cnv_valid,
  input wire logic cmd_rd,
  input wire logic cmd_wr,
  input wire logic rd_valid,
  input wire logic rd_miss,
  input wire logic [1:0] cnv_chan,
  input wire logic [7:0] cnv_code,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] rd_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic rq = cmd_rd & ~cmd_wr; // taken read
  wire logic mapped = cmd_code inside {8'h25, 8'h26, 8'hfe, 8'hff}; // code in the map
  sequence s_ur(c); cnv_valid && cnv_chan == c ##1 rq && !cnv_valid && cmd_code == 8'h25 + c / 2; endsequence
  property p_f(c, f); s_ur(c) |=> f == $past(cnv_code, 2); endproperty
  a_rd_answer: assert property (rq |=> rd_valid) else $error("late");
  a_word_hold: assert property (!rq |=> !rd_valid && $stable(rd_data)) else $error("hold");
  a_maker_code: assert property (rq && cmd_code == 8'hfe |=> rd_data == 16'h00a5) else $error("maker");
  a_part_code: assert property (rq && cmd_code == 8'hff |=> rd_data == 16'h003c) else $error("part");
  a_cur_byte: assert property (p_f(0, rd_data[15:8])) else $error("cur");
  a_cmp_byte: assert property (p_f(1, rd_data[7:0])) else $error("cmp");
  a_sys_byte: assert property (p_f(2, rd_data[15:8])) else $error("sys");
  a_bat_byte: assert property (p_f(3, rd_data[7:0])) else $error("bat");
  a_miss_flag: assert property (rq && !mapped |=> rd_miss && rd_data == 16'h0000) else $error("miss");
  a_miss_clear: assert property (!(rq && !mapped) |=> !rd_miss) else $error("stray miss");
endmodule
bind chgadc_regbank chgadc_monitor i_mon (.mclk, .resetn, .cnv_valid, .cmd_rd, .cmd_wr, .rd_valid, .rd_miss,
  .cnv_chan, .cnv_code, .cmd_code, .rd_data);

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`include "chgadc_regs.svh"
// ===
module testbench; // bench of the result bank
  logic mclk = 1'h0, resetn = 1'h0, cnv_valid = 1'h0, cmd_rd, cmd_wr, rd_valid, rd_miss, h;
  logic [1:0] cnv_chan = 2'h0;
  logic [7:0] cnv_code = 8'h00, cmd_code, a, f [4] = '{default: 8'h00};
  logic [15:0] cmd_wdata, rd_data;
  logic [17:0] e;
  int num_errors = 0, compares = 0;
  always #20 mclk = ~mclk;
  chgadc_regbank i_dut (.mclk, .resetn, .cnv_valid, .cnv_chan, .cnv_code, .cmd_rd, .cmd_wr, .cmd_code,
    .cmd_wdata, .rd_data, .rd_valid, .rd_miss);
  chgadc_host i_host (.mclk, .cmd_rd, .cmd_wr, .cmd_code, .cmd_wdata);
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    num_errors += int'(seen !== exp);
    if (seen !== exp)
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
  endtask
  task automatic rd(input logic [7:0] c, input logic [17:0] x); // answer judged one cycle on
    i_host.req(1'h1, c, 16'h0000);
    #1 check({rd_valid, rd_miss, rd_data}, x);
    @(posedge mclk);
  endtask
  task automatic sc_fields; // full scale, then small codes, read at once
    for (int k = 0; k < 8; k++)
    begin
      f[k % 4] = k < 4 ? 8'hff : 8'(k);
      h = k % 4 < 2;
      {cnv_valid, cnv_chan, cnv_code} <= {1'h1, 2'(k), f[k % 4]};
      @(posedge mclk);
      cnv_valid <= 1'h0;
      rd(h ? 8'h25 : 8'h26, {2'h2, h ? {f[0], f[1]} : {f[2], f[3]}});
    end
  endtask
  task automatic sc_writes; // writes dropped at all four mapped words
    for (int i = 0; i < 4; i++)
    begin
      a = i < 2 ? 8'h25 + 8'(i) : 8'hfc + 8'(i);
      e = i < 2 ? {2'h2, f[2 * i], f[2 * i + 1]} : i < 3 ? {2'h2, `CHGADC_MAKER_CODE} : {10'h200, `CHGADC_PART_CODE};
      i_host.req(1'h0, a, 16'hffff);
      @(posedge mclk);
      rd(a, e);
    end
    rd(8'h27, 18'h3_0000); // unmapped code
  endtask
  task automatic sc_both; // read and write at once is dropped
    i_host.req_both(8'h25);
    #1 check({rd_valid, rd_miss, rd_data}, 18'h0_0000);
    @(posedge mclk);
  endtask
  task automatic sc_reset; // mid-run reset clears every holder
    resetn <= 1'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'h1;
    rd(8'h25, 18'h2_0000);
    rd(8'h26, 18'h2_0000);
  endtask
  task automatic results;
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    sc_fields();
    sc_writes();
    sc_both();
    sc_reset();
    results();
  end
endmodule
